// [hdl/rtcb_ctrl.v]
// rtcb_ctrl.v: control plane of the clock peripheral: mode, output,
// routing and enable registers, oscillator start, fail flag, supply
// mode, test clearing and power-fail input enable.
// assumes: host on an async memory-like bus (cs/rd/wr low active),
// counters and timers outside, periodic events from sys_clk logic.
//
// Contract
// - periodic flag bit 7 enters/leaves test mode
// - zero to test register clears test conditions
// - rt mode bits 7:6 choose crystal frequency
// - clock start bit sets only if oscillating
// - periodic flag bit 6 reads oscillator failure
// - bit 6 write picks supply; backup needs osc
// - enable bit 7 opens power-fail input
// - backup irq bit holds power-fail enable set
// - rt mode register field layout
// - output mode selects sources, drive, polarity
// - routing bits steer five sources to pins
// - routing upper bits: save, low battery, delay
// - periodic enable register, one bit per source
// - flags clear on read edge; low battery live
`include "rtcb_map.vh"
`default_nettype none

module rtcb_ctrl (
	input wire sys_clk,
	input wire arst_n,
	input wire bus_cs_n,
	input wire bus_rd_n,
	input wire bus_wr_n,
	input wire [`RTCB_ADDR_W-1:0] bus_addr,
	input wire [`RTCB_DATA_W-1:0] bus_data_in,
	output reg [`RTCB_DATA_W-1:0] bus_data_out,
	output reg bus_data_oe_n,
	input wire osc_running,
	input wire battery_above_main,
	input wire low_battery,
	input wire [`RTCB_EVT_W-1:0] periodic_event,
	output reg [`RTCB_DATA_W-1:0] realtime_mode_cfg,
	output reg [`RTCB_DATA_W-1:0] pin_output_cfg,
	output reg [`RTCB_DATA_W-1:0] periodic_irq_enables,
	output reg [`RTCB_DATA_W-1:0] alarm_powerfail_irq_enables,
	output reg [`RTCB_DATA_W-1:0] irq_route_select,
	output reg [`RTCB_DATA_W-1:0] test_config,
	output reg [`RTCB_EVT_W-1:0] periodic_flags,
	output reg page_select,
	output reg register_bank_select,
	output reg test_mode,
	output reg battery_backed_mode,
	output reg osc_fail_flag,
	output wire crystal_select_high,
	output wire crystal_select_low,
	output wire power_loss_input_enable
);

	////////////////////////////////////////////////////////////////////////
	// synchronised pins
	wire [`RTCB_SYNC_W-1:0] sync_bus; // all async pins after two flops
	wire cs_s; // chip select, low active
	wire rd_s; // read strobe, low active
	wire wr_s; // write strobe, low active
	wire [`RTCB_ADDR_W-1:0] addr_s; // address
	wire [`RTCB_DATA_W-1:0] data_s; // write data
	wire osc_s; // oscillator running
	wire bat_s; // battery above main supply
	wire lowbat_s; // low battery comparator

	wire lowbat_in_w; // raw pins renamed for the concatenation
	wire bat_in_w;
	wire osc_in_w;
	assign lowbat_in_w = low_battery;
	assign bat_in_w = battery_above_main;
	assign osc_in_w = osc_running;

	// one synchroniser for the lot; strobes reset idle-high
	rtcb_sync #(
		.WIDTH(`RTCB_SYNC_W),
		.RST_VAL(`RTCB_SYNC_RST)
	) u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in({lowbat_in_w, bat_in_w, osc_in_w, bus_data_in,
			bus_addr, bus_wr_n, bus_rd_n, bus_cs_n}),
		.sync_out(sync_bus)
	);

	assign cs_s = sync_bus[`RTCB_SY_CS];
	assign rd_s = sync_bus[`RTCB_SY_RD];
	assign wr_s = sync_bus[`RTCB_SY_WR];
	assign addr_s = sync_bus[`RTCB_SY_ADDR_LO +: `RTCB_ADDR_W];
	assign data_s = sync_bus[`RTCB_SY_DATA_LO +: `RTCB_DATA_W];
	assign osc_s = sync_bus[`RTCB_SY_OSC];
	assign bat_s = sync_bus[`RTCB_SY_BAT];
	assign lowbat_s = sync_bus[`RTCB_SY_LOWBAT];

	////////////////////////////////////////////////////////////////////////
	// register decode, shared by the write and read paths
	function [`RTCB_SEL_W-1:0] reg_decode;
		input [`RTCB_ADDR_W-1:0] a;
		input pg;
		input bk;
		begin
			reg_decode = {`RTCB_SEL_W{1'b0}};
			if (a == `RTCB_OFS_STATUS) begin
				// status answers in both pages and banks
				reg_decode[`RTCB_SEL_STATUS] = 1'b1;
			end else if (!pg) begin
				case (a) // page 0 only
					`RTCB_OFS_TEST: begin
						reg_decode[`RTCB_SEL_TEST] = 1'b1;
					end
					`RTCB_OFS_1: begin
						reg_decode[`RTCB_SEL_RTMODE] = bk;
					end
					`RTCB_OFS_2: begin
						reg_decode[`RTCB_SEL_OUTCFG] = bk;
					end
					`RTCB_OFS_3: begin
						reg_decode[`RTCB_SEL_PIRQ] = bk;
						reg_decode[`RTCB_SEL_PFLAG] = ~bk;
					end
					`RTCB_OFS_4: begin
						reg_decode[`RTCB_SEL_APIRQ] = bk;
						reg_decode[`RTCB_SEL_ROUTE] = ~bk;
					end
					default: begin
						// timer and counter space lives elsewhere
					end
				endcase
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// strobe edges and latched access
	reg wr_q; // previous synced write strobe
	reg rd_q; // previous synced read strobe
	reg lat_cs_n; // chip select held during the strobe
	reg [`RTCB_ADDR_W-1:0] lat_addr; // address held during the strobe
	reg [`RTCB_DATA_W-1:0] lat_data; // data held during the strobe
	wire wr_take; // write taken at wr rising edge
	wire rd_done; // read ended at rd rising edge
	wire [`RTCB_SEL_W-1:0] wsel; // register hit by the finished access
	wire [`RTCB_SEL_W-1:0] rsel; // register hit by the running read

	// the bus is asynchronous: act on the trailing edge, with the
	// values latched while the strobe was low, so late bus changes
	// after the edge cannot corrupt the write
	assign wr_take = wr_s & ~wr_q & ~lat_cs_n;
	assign rd_done = rd_s & ~rd_q & ~lat_cs_n;
	assign wsel = reg_decode(lat_addr, page_select,
		register_bank_select);
	assign rsel = reg_decode(addr_s, page_select,
		register_bank_select);

	// latch address, data and select while either strobe is low
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= 1'b1;
			rd_q <= 1'b1;
			lat_cs_n <= 1'b1;
			lat_addr <= `RTCB_OFS_STATUS;
			lat_data <= `RTCB_RST_BYTE;
		end else begin
			wr_q <= wr_s;
			rd_q <= rd_s;
			if (!wr_s || !rd_s) begin
				lat_cs_n <= cs_s;
				lat_addr <= addr_s;
				lat_data <= data_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator fail flag
	// registered so that the read path and the supply check agree
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_fail_flag <= 1'b1; // assume no oscillation at reset
		end else begin
			// failure while not oscillating, unless test disables it
			osc_fail_flag <= ~osc_s &
				~test_config[`RTCB_TC_OSC_DIS];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// page, bank, test mode and supply mode
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			page_select <= 1'b0;
			register_bank_select <= 1'b0;
			test_mode <= 1'b0;
			battery_backed_mode <= ~`RTCB_RST_SINGLE;
		end else if (wr_take) begin
			if (wsel[`RTCB_SEL_STATUS]) begin
				page_select <= lat_data[`RTCB_ST_PAGE];
				register_bank_select <= lat_data[`RTCB_ST_BANK];
			end
			if (wsel[`RTCB_SEL_PFLAG]) begin
				test_mode <= lat_data[`RTCB_PF_TEST];
				if (lat_data[`RTCB_PF_SUPPLY]) begin
					battery_backed_mode <= 1'b0; // single supply
				end else if (!osc_fail_flag) begin
					battery_backed_mode <= 1'b1; // backup needs osc
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// test configuration
	// only writable inside test mode, so a stray write in normal
	// operation cannot switch test features on
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			test_config <= `RTCB_RST_BYTE;
		end else if (wr_take && wsel[`RTCB_SEL_TEST] && test_mode) begin
			// a zero write clears every condition, fail disable too
			test_config <= lat_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// real time mode register
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			realtime_mode_cfg <= `RTCB_RST_BYTE;
		end else if (wr_take && wsel[`RTCB_SEL_RTMODE]) begin
			// crystal, backup enables, hour mode, leap count
			realtime_mode_cfg <= lat_data;
			// start bit refuses a 1 while not oscillating
			realtime_mode_cfg[`RTCB_RT_CLK_RUN] <=
				lat_data[`RTCB_RT_CLK_RUN] & osc_s;
		end
	end

	// crystal frequency select straight from the register bits
	assign crystal_select_high = realtime_mode_cfg[`RTCB_RT_XHI];
	assign crystal_select_low = realtime_mode_cfg[`RTCB_RT_XLO];

	////////////////////////////////////////////////////////////////////////
	// output mode and periodic enable registers
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_output_cfg <= `RTCB_RST_BYTE;
			periodic_irq_enables <= `RTCB_RST_BYTE;
		end else if (wr_take) begin
			if (wsel[`RTCB_SEL_OUTCFG]) begin
				// source, drive type and polarity of both pins
				pin_output_cfg <= lat_data;
			end
			if (wsel[`RTCB_SEL_PIRQ]) begin
				// timer 1 down to minute enables
				periodic_irq_enables <= lat_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alarm / power-fail enable register
	wire pf_hold; // backup keeps the power-fail enable set
	assign pf_hold = realtime_mode_cfg[`RTCB_RT_IRQ_BK] & bat_s;

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_powerfail_irq_enables <= `RTCB_RST_BYTE;
		end else begin
			if (wr_take && wsel[`RTCB_SEL_APIRQ]) begin
				alarm_powerfail_irq_enables <= lat_data;
			end
			// later assignment wins over a write of zero
			if (pf_hold) begin
				alarm_powerfail_irq_enables[`RTCB_AP_PF_EN] <= 1'b1;
			end
		end
	end

	// enable for the power-loss pin and its detector
	assign power_loss_input_enable =
		alarm_powerfail_irq_enables[`RTCB_AP_PF_EN];

	////////////////////////////////////////////////////////////////////////
	// routing register
	// low battery bit is not stored: it reads the live comparator
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_route_select <= `RTCB_RST_BYTE;
		end else if (wr_take && wsel[`RTCB_SEL_ROUTE]) begin
			// per-source pin steering and upper controls
			irq_route_select <= lat_data & `RTCB_ROUTE_RW_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// periodic flags, sticky, cleared by the read that saw them
	wire [`RTCB_EVT_W-1:0] flag_clr; // bits shown by the finished read
	assign flag_clr = (rd_done && wsel[`RTCB_SEL_PFLAG]) ?
		bus_data_out[`RTCB_EVT_W-1:0] : `RTCB_RST_EVT;

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			periodic_flags <= `RTCB_RST_EVT;
		end else begin
			// clear only what was shown; a new event wins
			periodic_flags <= (periodic_flags & ~flag_clr) |
				periodic_event;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data
	reg [`RTCB_DATA_W-1:0] rd_val; // value of the addressed register

	always @* begin
		rd_val = `RTCB_RST_BYTE;
		if (rsel[`RTCB_SEL_STATUS]) begin
			rd_val[`RTCB_ST_BANK] = register_bank_select;
			rd_val[`RTCB_ST_PAGE] = page_select;
		end
		if (rsel[`RTCB_SEL_RTMODE]) begin
			rd_val = realtime_mode_cfg;
		end
		if (rsel[`RTCB_SEL_OUTCFG]) begin
			rd_val = pin_output_cfg;
		end
		if (rsel[`RTCB_SEL_PIRQ]) begin
			rd_val = periodic_irq_enables;
		end
		if (rsel[`RTCB_SEL_APIRQ]) begin
			rd_val = alarm_powerfail_irq_enables;
		end
		if (rsel[`RTCB_SEL_PFLAG]) begin
			rd_val[`RTCB_EVT_W-1:0] = periodic_flags;
			rd_val[`RTCB_PF_SUPPLY] = osc_fail_flag;
			rd_val[`RTCB_PF_TEST] = test_mode;
		end
		if (rsel[`RTCB_SEL_ROUTE]) begin
			rd_val = irq_route_select;
			rd_val[`RTCB_RO_LOWBAT] = lowbat_s; // live level
		end
		if (rsel[`RTCB_SEL_TEST]) begin
			rd_val = test_config;
		end
	end

	// drive the bus while selected and reading; oe is low active
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_data_out <= `RTCB_RST_BYTE;
			bus_data_oe_n <= 1'b1;
		end else if (!cs_s && !rd_s) begin
			bus_data_out <= rd_val;
			bus_data_oe_n <= 1'b0;
		end else begin
			// keep the last value so the read clear knows what was seen
			bus_data_oe_n <= 1'b1;
		end
	end

endmodule // rtcb_ctrl
`default_nettype wire

// [hdl/rtcb_map.vh]
// rtcb_map.vh: offsets, bit positions and reset values of the
// oscillator / backup control block.
// assumes: included by bare name from the design files under hdl/.
`ifndef RTCB_MAP_VH
`define RTCB_MAP_VH

////////////////////////////////////////////////////////////////////////
// bus widths
`define RTCB_ADDR_W 5
`define RTCB_DATA_W 8
`define RTCB_EVT_W 6

////////////////////////////////////////////////////////////////////////
// offsets on the parallel bus
`define RTCB_OFS_STATUS 5'h00
`define RTCB_OFS_1 5'h01
`define RTCB_OFS_2 5'h02
`define RTCB_OFS_3 5'h03
`define RTCB_OFS_4 5'h04
`define RTCB_OFS_TEST 5'h1f

////////////////////////////////////////////////////////////////////////
// one-hot register select positions
`define RTCB_SEL_W 8
`define RTCB_SEL_STATUS 0
`define RTCB_SEL_RTMODE 1
`define RTCB_SEL_OUTCFG 2
`define RTCB_SEL_PIRQ 3
`define RTCB_SEL_APIRQ 4
`define RTCB_SEL_PFLAG 5
`define RTCB_SEL_ROUTE 6
`define RTCB_SEL_TEST 7

////////////////////////////////////////////////////////////////////////
// field positions
`define RTCB_ST_BANK 7
`define RTCB_ST_PAGE 6
`define RTCB_PF_TEST 7
`define RTCB_PF_SUPPLY 6
`define RTCB_RT_XHI 7
`define RTCB_RT_XLO 6
`define RTCB_RT_IRQ_BK 4
`define RTCB_RT_CLK_RUN 3
`define RTCB_AP_PF_EN 7
`define RTCB_RO_LOWBAT 6
`define RTCB_TC_OSC_DIS 0

////////////////////////////////////////////////////////////////////////
// reset values, route write mask and synchroniser width
`define RTCB_RST_BYTE 8'h00
`define RTCB_RST_EVT 6'h00
`define RTCB_RST_SINGLE 1'b1
`define RTCB_ROUTE_RW_MASK 8'hbf
`define RTCB_SYNC_W 19
// positions inside the synchroniser vector
`define RTCB_SY_CS 0
`define RTCB_SY_RD 1
`define RTCB_SY_WR 2
`define RTCB_SY_ADDR_LO 3
`define RTCB_SY_DATA_LO 8
`define RTCB_SY_OSC 16
`define RTCB_SY_BAT 17
`define RTCB_SY_LOWBAT 18
// chip select and strobes idle high, everything else low
`define RTCB_SYNC_RST 19'h00007

`endif

// [hdl/rtcb_sync.v]
// rtcb_sync.v: two-flop synchroniser for a vector of async levels.
// assumes: each bit is a level; buses are qualified by strobes later.
`default_nettype none

module rtcb_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input wire sys_clk,
	input wire arst_n,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta; // first stage, read only by sync_out

	////////////////////////////////////////////////////////////////////////
	// two stages, reset to constant idle levels
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule // rtcb_sync
`default_nettype wire

// [tb/rtcb_ctrl_properties.sv]
// rtcb_ctrl_properties.sv: checker of the control block's port relations.
// assumes: bound into rtcb_ctrl; one clock, async low reset.
`default_nettype none

module rtcb_ctrl_chk (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic bus_cs_n,
	input wire logic bus_rd_n,
	input wire logic bus_data_oe_n,
	input wire logic osc_running,
	input wire logic battery_above_main,
	input wire logic [5:0] periodic_event,
	input wire logic [7:0] realtime_mode_cfg,
	input wire logic [7:0] irq_route_select,
	input wire logic [7:0] test_config,
	input wire logic [5:0] periodic_flags,
	input wire logic test_mode,
	input wire logic battery_backed_mode,
	input wire logic osc_fail_flag,
	input wire logic crystal_select_high,
	input wire logic crystal_select_low,
	input wire logic power_loss_input_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////
	// four cycles give the input synchroniser time to settle
	sequence s_osc_stopped;
		(!osc_running && !test_config[0]) [*4];
	endsequence
	sequence s_backup_hold;
		(realtime_mode_cfg[4] && battery_above_main) [*4];
	endsequence

	////////////////////////////////////////////////////////////////////////
	a_xtal_pins: assert property (
		{crystal_select_high, crystal_select_low} == realtime_mode_cfg[7:6])
		else $error("crystal pins differ from mode bits");
	a_clk_start_gate: assert property (
		$rose(realtime_mode_cfg[3]) |-> $past(osc_running, 3))
		else $error("clock start set without oscillator");
	a_fail_flag_set: assert property (
		s_osc_stopped |-> osc_fail_flag)
		else $error("fail flag low while stopped");
	a_fail_flag_clr: assert property (
		osc_running [*4] |-> !osc_fail_flag)
		else $error("fail flag high while running");
	a_backup_guard: assert property (
		$rose(battery_backed_mode) |-> !$past(osc_fail_flag))
		else $error("backup mode taken during fail");
	a_test_guard: assert property (
		$changed(test_config) |-> $past(test_mode))
		else $error("test register changed outside test");
	a_pf_hold: assert property (
		s_backup_hold |-> power_loss_input_enable)
		else $error("power loss enable dropped on backup");
	a_flag_set: assert property (
		periodic_event[0] |=> periodic_flags[0])
		else $error("event did not set flag");
	a_oe_cause: assert property (
		$fell(bus_data_oe_n) |->
		$past(!bus_cs_n && !bus_rd_n, 2) || $past(!bus_cs_n && !bus_rd_n, 3))
		else $error("data driven without read");
	a_oe_release: assert property (
		$rose(bus_rd_n) |-> ##[1:5] bus_data_oe_n)
		else $error("data not released");
	a_route_ro: assert property (
		irq_route_select[6] == 1'b0)
		else $error("low battery bit stored");
endmodule // rtcb_ctrl_chk

bind rtcb_ctrl rtcb_ctrl_chk u_chk (.sys_clk, .arst_n, .bus_cs_n,
	.bus_rd_n, .bus_data_oe_n, .osc_running, .battery_above_main,
	.periodic_event, .realtime_mode_cfg, .irq_route_select, .test_config,
	.periodic_flags, .test_mode, .battery_backed_mode, .osc_fail_flag,
	.crystal_select_high, .crystal_select_low, .power_loss_input_enable);
`default_nettype wire

// [tb/rtcb_ctrl_tb.sv]
// rtcb_ctrl_tb.sv: self-checking bench of the oscillator control block.
// assumes: host model drives the bus; bench drives the analog levels.
`default_nettype none

module rtcb_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, arst_n, osc_running, battery_above_main, low_battery;
	logic bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe_n;
	logic [4:0] bus_addr;
	logic [5:0] periodic_event, periodic_flags;
	logic [7:0] bus_data_in, bus_data_out, realtime_mode_cfg, pin_output_cfg;
	logic [7:0] periodic_irq_enables, alarm_powerfail_irq_enables;
	logic [7:0] irq_route_select, test_config, v;
	logic page_select, register_bank_select, test_mode, battery_backed_mode;
	logic osc_fail_flag, crystal_select_high, crystal_select_low;
	logic power_loss_input_enable;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	rtcb_ctrl u_rtcb_ctrl (.*);
	rtcb_host u_rtcb_host (.*);

	////////////////////////////////////////////////////////////////////////
	// 40 ns clock, cycle ceiling well above the ~420 cycles needed
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares = miscompares + 1;
			stop_test();
		end
	end

	task stop_test();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// read one offset and compare
	task rdc(input logic [4:0] a, input logic [7:0] exp);
		u_rtcb_host.rd(a, v);
		chk(v, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		osc_running = 1'b0;
		battery_above_main = 1'b0;
		low_battery = 1'b0;
		periodic_event = 6'h00;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// test mode in and out, test register set, zero-cleared and refused outside, bank 0
		u_rtcb_host.wr(5'h00, 8'h00);
		u_rtcb_host.wr(5'h03, 8'hc0);
		chk({7'h00, test_mode}, 8'h01);
		u_rtcb_host.wr(5'h1f, 8'h01);
		chk(test_config, 8'h01);
		rdc(5'h1f, 8'h01);
		u_rtcb_host.wr(5'h1f, 8'h00);
		chk(test_config, 8'h00);
		u_rtcb_host.wr(5'h03, 8'h40);
		chk({7'h00, test_mode}, 8'h00);
		u_rtcb_host.wr(5'h1f, 8'h01);
		chk(test_config, 8'h00);
		rdc(5'h1f, 8'h00);
		// backup mode refused while the oscillator is dead
		u_rtcb_host.wr(5'h03, 8'h00);
		chk({7'h00, battery_backed_mode}, 8'h00);
		rdc(5'h03, 8'h40);
		// bank 1: every crystal code, start refused
		u_rtcb_host.wr(5'h00, 8'h80);
		for (int i = 0; i < 4; i++) begin
			u_rtcb_host.wr(5'h01, {i[1:0], 6'h08});
			chk(realtime_mode_cfg, {i[1:0], 6'h00});
			chk({6'h00, crystal_select_high, crystal_select_low},
				{6'h00, i[1:0]});
		end
		osc_running <= 1'b1;
		repeat (6) @(posedge sys_clk);
		u_rtcb_host.wr(5'h01, 8'hc8);
		chk(realtime_mode_cfg, 8'hc8);
		u_rtcb_host.wr(5'h02, 8'ha5);
		rdc(5'h02, 8'ha5);
		u_rtcb_host.wr(5'h03, 8'h5a);
		rdc(5'h03, 8'h5a);
		u_rtcb_host.wr(5'h04, 8'h80);
		chk({7'h00, power_loss_input_enable}, 8'h01);
		// enable held on battery when irq-on-backup is set
		u_rtcb_host.wr(5'h01, 8'hd8);
		battery_above_main <= 1'b1;
		u_rtcb_host.wr(5'h04, 8'h00);
		rdc(5'h04, 8'h80);
		battery_above_main <= 1'b0;
		u_rtcb_host.wr(5'h04, 8'h00);
		rdc(5'h04, 8'h00);
		// bank 0: status, supply mode, routing
		u_rtcb_host.wr(5'h00, 8'h00);
		rdc(5'h03, 8'h00);
		u_rtcb_host.wr(5'h03, 8'h00);
		chk({7'h00, battery_backed_mode}, 8'h01);
		u_rtcb_host.wr(5'h04, 8'hff);
		rdc(5'h04, 8'hbf);
		low_battery <= 1'b1;
		rdc(5'h04, 8'hff);
		// read-clear of a sticky periodic flag
		@(posedge sys_clk);
		periodic_event <= 6'h01;
		@(posedge sys_clk);
		periodic_event <= 6'h00;
		rdc(5'h03, 8'h01);
		rdc(5'h03, 8'h00);
		// bank and page steering, unmapped offset
		rdc(5'h01, 8'h00);
		rdc(5'h10, 8'h00);
		u_rtcb_host.wr(5'h00, 8'h40);
		rdc(5'h00, 8'h40);
		rdc(5'h04, 8'h00);
		stop_test();
	end
endmodule // rtcb_ctrl_tb
`default_nettype wire

// [tb/rtcb_host.sv]
// rtcb_host.sv: host cpu model on the async register bus.
// assumes: write strobe held 4 clocks, read strobe 5, idle 5; read data sampled in the cycle.
`default_nettype none

module rtcb_host (
	input wire logic sys_clk,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe_n,
	output logic bus_cs_n,
	output logic bus_rd_n,
	output logic bus_wr_n,
	output logic [4:0] bus_addr,
	output logic [7:0] bus_data_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial begin
		bus_cs_n = 1'b1;
		bus_rd_n = 1'b1;
		bus_wr_n = 1'b1;
		bus_addr = 5'h00;
		bus_data_in = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// released lines show the inverse, so stale values never look valid
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_cs_n <= 1'b0;
		bus_wr_n <= 1'b0;
		bus_addr <= a;
		bus_data_in <= d;
		repeat (4) @(posedge sys_clk);
		bus_cs_n <= 1'b1;
		bus_wr_n <= 1'b1;
		bus_addr <= ~a;
		bus_data_in <= ~d;
		repeat (5) @(posedge sys_clk);
	endtask

	// unknown returned when the block is not driving
	task rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		bus_cs_n <= 1'b0;
		bus_rd_n <= 1'b0;
		bus_addr <= a;
		repeat (5) @(posedge sys_clk);
		v = (bus_data_oe_n !== 1'b0) ? 8'hxx : bus_data_out;
		bus_cs_n <= 1'b1;
		bus_rd_n <= 1'b1;
		bus_addr <= ~a;
		repeat (5) @(posedge sys_clk);
	endtask
endmodule // rtcb_host
`default_nettype wire
